// ### scm_defs.vh
`ifndef SCM_DEFS_VH
`define SCM_DEFS_VH

// Register map (byte address of the single control word)
`define SCM_CTRL_ADDR        8'h00

// Field positions of system_clock_control
`define SCM_SEL_MSB          7
`define SCM_SEL_LSB          5
`define SCM_STABLE_BIT       3
`define SCM_HS_EN_BIT        2
`define SCM_HS_KEEP_BIT      1
`define SCM_LS_KEEP_BIT      0

// Reset values
`define SCM_SEL_RST          3'h7
`define SCM_SEL_SLOW         3'h7

// Source rates and the hclk rate
`define SCM_HCLK_HZ          100000000
`define SCM_HS_HZ            4000000
`define SCM_LS_HZ            32000
`define SCM_HS_DIV           (`SCM_HCLK_HZ / `SCM_HS_HZ)
`define SCM_LS_DIV           (`SCM_HCLK_HZ / `SCM_LS_HZ)

// High-speed oscillator start-up time, in ns, and in hclk cycles
`define SCM_HCLK_NS          10
`define SCM_HS_STAB_NS       16000
`define SCM_HS_STAB_CYC      ((`SCM_HS_STAB_NS + `SCM_HCLK_NS - 1) / `SCM_HCLK_NS)

// Terminal counts of the tick and start-up counters, sized to their counters
`define SCM_HS_TICK_LAST     6'h18
`define SCM_LS_TICK_LAST     12'hc34
`define SCM_HS_STAB_LAST     12'h63f

// Current-clock periods waited before a source change
`define SCM_SW_WAIT          3'h4

// Operating mode codes
`define SCM_MODE_FAST        3'h0
`define SCM_MODE_SLOW        3'h1
`define SCM_MODE_SLEEP       3'h2
`define SCM_MODE_IDLE_LS     3'h3
`define SCM_MODE_IDLE_BOTH   3'h4
`define SCM_MODE_IDLE_HS     3'h5

`endif

// ### scm_clock_ctrl.v
`timescale 1ns/10ps
`include "scm_defs.vh"
// Summary of operation
// - Select codes 0..6 give hs_clk divided by 1..64; code 7 gives ls_clk.
// - hs_clk comes from the 4MHz oscillator, ls_clk from the 32kHz one.
// - FAST: CPU runs on divided hs_clk; hs_clk, ls_clk and ls oscillator run.
// - SLOW: CPU runs on ls_clk; ls_clk and ls oscillator run.
// - In SLOW, hs_osc_en decides whether the hs oscillator keeps running.
// - Halt with both keep bits 0 enters SLEEP; CPU, sys, hs, ls feeds stop.
// - In SLEEP the ls oscillator runs only while the watchdog is enabled.
// - Halt with ls keep only: idle_ls_only; sys_clk on only for code 7.
// - Halt with both keeps: idle_both_osc; all clocks run, CPU stops.
// - Halt with hs keep only: idle_hs_only; sys_clk on only for codes 0..6.
// - Bit 2 hs_osc_en is read/write enable of the hs oscillator in SLOW mode.
// - Bit 3 stable flag clears while the hs oscillator is off, sets once it settles.
// - Bit 1 hs_osc_halt_keep keeps the hs oscillator alive through halt.
// - Bit 0 ls_osc_halt_keep keeps the ls oscillator alive through halt.
// - Source change completes after four current periods and a target edge.
module scm_clock_ctrl
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata_ff,
    output reg         hreadyout_ff,
    output reg         hresp_ff,
    input  wire        halt_req,
    input  wire        wake_req,
    input  wire        wdt_en,
    output reg         sys_clk_en_ff,
    output reg         cpu_clk_en_ff,
    output reg         hs_clk_en_ff,
    output reg         ls_clk_en_ff,
    output reg         hs_osc_on_ff,
    output reg         ls_osc_on_ff,
    output reg  [2:0]  op_mode_ff
);

//------------------------------------------------------------
// Declarations
//------------------------------------------------------------
reg  [2:0]  sel_ff;
reg         hs_en_ff;
reg         hs_keep_ff;
reg         ls_keep_ff;
reg         stable_ff;
reg  [2:0]  act_sel_ff;
reg         pend_ff;
reg  [2:0]  wait_cnt_ff;
reg         halted_ff;
reg         wr_pend_ff;
reg  [5:0]  hs_cnt_ff;
reg  [11:0] ls_cnt_ff;
reg  [5:0]  hs_div_ff;
reg  [11:0] stab_cnt_ff;
reg         nxt_hs_osc;
reg         nxt_ls_osc;
reg  [2:0]  nxt_mode;
reg         nxt_sys_on;
reg  [7:0]  ctrl_rd;
wire        addr_ok;
wire        rd_req;
wire        wr_req;
wire        hs_tick;
wire        ls_tick;
wire        cur_tick;
wire        tgt_tick;

// Tick of the source chosen by a select code
function src_tick;
    input [2:0] sel;
    input       hs_t;
    input       ls_t;
    input [5:0] div;
    reg   [5:0] mask;
    begin
        mask = 6'h3f >> (3'h6 - sel);
        if (sel == `SCM_SEL_SLOW)
            src_tick = ls_t;
        else
            src_tick = hs_t && ((div & mask) == mask);
    end
endfunction

//------------------------------------------------------------
// AHB-Lite register access
//------------------------------------------------------------
assign addr_ok = (haddr[7:0] == `SCM_CTRL_ADDR) && (haddr[31:8] == 24'h000000);
assign rd_req  = hsel && hready && htrans[1] && !hwrite;
assign wr_req  = hsel && hready && htrans[1] && hwrite && addr_ok;

// Readback image; unused bit 4 reads zero
// bit 4 zero
always @*
begin
    ctrl_rd = {sel_ff, 1'b0, stable_ff, hs_en_ff, hs_keep_ff, ls_keep_ff};
    if (wr_pend_ff)
        ctrl_rd = {hwdata[7:5], 1'b0, stable_ff, hwdata[2:0]};
end

// Zero-wait slave, always OKAY; read data formed in the address phase
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        hrdata_ff    <= 32'h00000000;
        hreadyout_ff <= 1'b1;
        hresp_ff     <= 1'b0;
        wr_pend_ff   <= 1'b0;
    end
    else
    begin
        hreadyout_ff <= 1'b1;
        hresp_ff     <= 1'b0;
        if (hready)
            wr_pend_ff <= wr_req;
        if (rd_req)
            hrdata_ff <= addr_ok ? {24'h000000, ctrl_rd} : 32'h00000000;
    end
end

// Control register write in the data phase
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        sel_ff     <= `SCM_SEL_RST;
        hs_en_ff   <= 1'b0;
        hs_keep_ff <= 1'b0;
        ls_keep_ff <= 1'b0;
    end
    else if (wr_pend_ff)
    begin
        sel_ff     <= hwdata[`SCM_SEL_MSB:`SCM_SEL_LSB];
        hs_en_ff   <= hwdata[`SCM_HS_EN_BIT];
        hs_keep_ff <= hwdata[`SCM_HS_KEEP_BIT];
        ls_keep_ff <= hwdata[`SCM_LS_KEEP_BIT];
    end
end

//------------------------------------------------------------
// Oscillator models
//------------------------------------------------------------
// 4MHz and 32kHz tick rates
assign hs_tick = hs_osc_on_ff && stable_ff && (hs_cnt_ff == `SCM_HS_TICK_LAST);
assign ls_tick = ls_osc_on_ff && (ls_cnt_ff == `SCM_LS_TICK_LAST);

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        hs_cnt_ff <= 6'h00;
        ls_cnt_ff <= 12'h000;
        hs_div_ff <= 6'h00;
    end
    else
    begin
        if (!hs_osc_on_ff || !stable_ff || hs_tick)
            hs_cnt_ff <= 6'h00;
        else
            hs_cnt_ff <= hs_cnt_ff + 6'h01;
        if (!ls_osc_on_ff || ls_tick)
            ls_cnt_ff <= 12'h000;
        else
            ls_cnt_ff <= ls_cnt_ff + 12'h001;
        if (hs_tick)
            hs_div_ff <= hs_div_ff + 6'h01;
    end
end

// Start-up timer of the hs oscillator and its stable flag
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        stab_cnt_ff <= 12'h000;
        stable_ff   <= 1'b0;
    end
    else if (!hs_osc_on_ff)
    begin
        // flag cleared while oscillator is off
        stab_cnt_ff <= 12'h000;
        stable_ff   <= 1'b0;
    end
    else if (!stable_ff)
    begin
        if (stab_cnt_ff == `SCM_HS_STAB_LAST)
            stable_ff <= 1'b1;
        else
            stab_cnt_ff <= stab_cnt_ff + 12'h001;
    end
end

//------------------------------------------------------------
// Glitch-free source change
//------------------------------------------------------------
// decode of select codes
assign cur_tick = src_tick(act_sel_ff, hs_tick, ls_tick, hs_div_ff);
assign tgt_tick = src_tick(sel_ff, hs_tick, ls_tick, hs_div_ff);

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        act_sel_ff  <= `SCM_SEL_RST;
        pend_ff     <= 1'b0;
        wait_cnt_ff <= 3'h0;
    end
    else if (wr_pend_ff && (hwdata[`SCM_SEL_MSB:`SCM_SEL_LSB] != act_sel_ff))
    begin
        pend_ff     <= 1'b1;
        wait_cnt_ff <= 3'h0;
    end
    else if (pend_ff)
    begin
        // four current periods, then target edge
        if (wait_cnt_ff != `SCM_SW_WAIT)
        begin
            if (cur_tick)
                wait_cnt_ff <= wait_cnt_ff + 3'h1;
        end
        // change over on a target edge
        else if (tgt_tick)
        begin
            act_sel_ff <= sel_ff;
            pend_ff    <= 1'b0;
        end
    end
end

//------------------------------------------------------------
// Operating mode and clock gating
//------------------------------------------------------------
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
        halted_ff <= 1'b0;
    else if (wake_req)
        halted_ff <= 1'b0;
    else if (halt_req)
        halted_ff <= 1'b1;
end

always @*
begin
    nxt_mode   = `SCM_MODE_SLOW;
    nxt_sys_on = 1'b1;
    nxt_hs_osc = 1'b1;
    nxt_ls_osc = 1'b1;
    case ({halted_ff, hs_keep_ff, ls_keep_ff})
        3'h4:
        begin
            nxt_mode   = `SCM_MODE_SLEEP;
            nxt_sys_on = 1'b0;
            nxt_hs_osc = 1'b0;
            nxt_ls_osc = wdt_en;
        end
        3'h5:
        begin
            nxt_mode   = `SCM_MODE_IDLE_LS;
            nxt_sys_on = (act_sel_ff == `SCM_SEL_SLOW);
            nxt_hs_osc = 1'b0;
        end
        3'h7:
        begin
            nxt_mode   = `SCM_MODE_IDLE_BOTH;
        end
        3'h6:
        begin
            nxt_mode   = `SCM_MODE_IDLE_HS;
            nxt_sys_on = (act_sel_ff != `SCM_SEL_SLOW);
        end
        default:
        begin
            if ((act_sel_ff != `SCM_SEL_SLOW) || (sel_ff != `SCM_SEL_SLOW))
                nxt_mode = `SCM_MODE_FAST;
            else
                // slow: enable bit rules hs oscillator
                nxt_hs_osc = hs_en_ff;
            // ls oscillator runs in normal modes
            nxt_ls_osc = 1'b1;
        end
    endcase
end

// Registered clock enables and status outputs
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        sys_clk_en_ff <= 1'b0;
        cpu_clk_en_ff <= 1'b0;
        hs_clk_en_ff  <= 1'b0;
        ls_clk_en_ff  <= 1'b0;
        hs_osc_on_ff  <= 1'b0;
        ls_osc_on_ff  <= 1'b0;
        op_mode_ff    <= `SCM_MODE_SLOW;
    end
    else
    begin
        hs_osc_on_ff  <= nxt_hs_osc;
        ls_osc_on_ff  <= nxt_ls_osc;
        op_mode_ff    <= nxt_mode;
        sys_clk_en_ff <= nxt_sys_on && cur_tick;
        cpu_clk_en_ff <= !halted_ff && cur_tick;
        hs_clk_en_ff  <= hs_tick;
        // ls feed to peripherals stops in sleep and idle_hs_only
        ls_clk_en_ff  <= ls_tick && !(halted_ff && !ls_keep_ff);
    end
end

endmodule // scm_clock_ctrl

// ### scm_asserts.sv
`timescale 1ns/10ps
`include "scm_defs.vh"
module scm_asserts
(
    input wire        hclk,
    input wire        hresetn,
    input wire        halt_req,
    input wire        wake_req,
    input wire        wdt_en,
    input wire [31:0] hrdata_ff,
    input wire        sys_clk_en_ff,
    input wire        cpu_clk_en_ff,
    input wire        hs_clk_en_ff,
    input wire        ls_clk_en_ff,
    input wire        ls_osc_on_ff,
    input wire [2:0]  op_mode_ff
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------------------------------------------------------
    // Mode and gating checks
    // ----------------------------------------------------------------
    // unused bit
    a_bit4_zero: assert property (hrdata_ff[4] == 1'b0) else $error("bit 4 set");
    a_cpu_in_sys: assert property (cpu_clk_en_ff |-> sys_clk_en_ff) else $error("cpu tick alone");
    a_halt_enter: assert property (halt_req && !wake_req |-> ##2 op_mode_ff >= `SCM_MODE_SLEEP)
        else $error("no halt mode");
    a_sleep_gates: assert property (op_mode_ff == `SCM_MODE_SLEEP && $past(op_mode_ff) == `SCM_MODE_SLEEP
        |-> !sys_clk_en_ff && !hs_clk_en_ff && !ls_clk_en_ff) else $error("tick in sleep");
    a_sleep_wdt: assert property (op_mode_ff == `SCM_MODE_SLEEP && $past(op_mode_ff) == `SCM_MODE_SLEEP
        && $stable(wdt_en) |-> ls_osc_on_ff == wdt_en) else $error("ls osc vs wdt");
    a_idle_ls: assert property (op_mode_ff == `SCM_MODE_IDLE_LS && $past(op_mode_ff) == op_mode_ff
        |-> !hs_clk_en_ff && !cpu_clk_en_ff) else $error("idle ls gating");
    a_idle_hs: assert property (op_mode_ff == `SCM_MODE_IDLE_HS && $past(op_mode_ff) == op_mode_ff
        |-> !ls_clk_en_ff && !cpu_clk_en_ff) else $error("idle hs gating");
    a_run_lsosc: assert property (op_mode_ff <= `SCM_MODE_SLOW && $past(hresetn) |-> ls_osc_on_ff)
        else $error("ls osc off while running");
    a_hs_gap: assert property (hs_clk_en_ff |=> !hs_clk_en_ff [*8]) else $error("hs ticks too close");
    c_sleep: cover property (op_mode_ff == `SCM_MODE_SLEEP);
    c_both: cover property (op_mode_ff == `SCM_MODE_IDLE_BOTH && hs_clk_en_ff);
    c_fast: cover property (op_mode_ff == `SCM_MODE_FAST && sys_clk_en_ff);
endmodule // scm_asserts
bind scm_clock_ctrl scm_asserts i_chk (.hclk(hclk), .hresetn(hresetn), .halt_req(halt_req),
    .wake_req(wake_req), .wdt_en(wdt_en), .hrdata_ff(hrdata_ff), .sys_clk_en_ff(sys_clk_en_ff),
    .cpu_clk_en_ff(cpu_clk_en_ff), .hs_clk_en_ff(hs_clk_en_ff), .ls_clk_en_ff(ls_clk_en_ff),
    .ls_osc_on_ff(ls_osc_on_ff), .op_mode_ff(op_mode_ff));

// ### scm_cpu_model.sv
`timescale 1ns/10ps
module scm_cpu_model
(
    input  wire hclk,
    input  wire hresetn,
    input  wire go_halt,
    input  wire go_wake,
    input  wire sys_clk_en_ff,
    input  wire hs_clk_en_ff,
    input  wire ls_clk_en_ff,
    output reg  halt_req_ff,
    output reg  wake_req_ff,
    output int  n_sys_ff,
    output int  n_hs_ff,
    output int  n_ls_ff
);
    always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
        {halt_req_ff, wake_req_ff} <= 2'h0;
        {n_sys_ff, n_hs_ff, n_ls_ff} <= '0;
    end
    else
    begin
        halt_req_ff <= go_halt;
        wake_req_ff <= go_wake;
        n_sys_ff <= n_sys_ff + sys_clk_en_ff;
        n_hs_ff <= n_hs_ff + hs_clk_en_ff;
        n_ls_ff <= n_ls_ff + ls_clk_en_ff;
    end
endmodule // scm_cpu_model

// ### test_system_clock_mode_control.sv
`timescale 1ns/10ps
`include "scm_defs.vh"
module test_system_clock_mode_control;
    logic        hclk, hresetn, hsel, hwrite, wdt_en, go_halt, go_wake;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    wire  [31:0] hrdata_ff;
    wire  [2:0]  op_mode_ff;
    wire         hready, hresp_ff, halt_req_ff, wake_req_ff, sys_clk_en_ff, cpu_clk_en_ff;
    wire         hs_clk_en_ff, ls_clk_en_ff, hs_osc_on_ff, ls_osc_on_ff;
    int          n_fail, cmp_count, cyc, n_sys_ff, n_hs_ff, n_ls_ff, s0, h0, l0, g, i, n_cpu, c0;
    logic [2:0]  md [5] = '{`SCM_MODE_SLEEP, `SCM_MODE_IDLE_LS, `SCM_MODE_IDLE_HS, `SCM_MODE_IDLE_BOTH,
                            `SCM_MODE_SLEEP};
    scm_clock_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata_ff(hrdata_ff),
        .hreadyout_ff(hready), .hresp_ff(hresp_ff), .halt_req(halt_req_ff), .wake_req(wake_req_ff),
        .wdt_en(wdt_en), .sys_clk_en_ff(sys_clk_en_ff), .cpu_clk_en_ff(cpu_clk_en_ff),
        .hs_clk_en_ff(hs_clk_en_ff), .ls_clk_en_ff(ls_clk_en_ff), .hs_osc_on_ff(hs_osc_on_ff),
        .ls_osc_on_ff(ls_osc_on_ff), .op_mode_ff(op_mode_ff));
    scm_cpu_model i_cpu (.hclk(hclk), .hresetn(hresetn), .go_halt(go_halt), .go_wake(go_wake),
        .sys_clk_en_ff(sys_clk_en_ff), .hs_clk_en_ff(hs_clk_en_ff), .ls_clk_en_ff(ls_clk_en_ff),
        .halt_req_ff(halt_req_ff), .wake_req_ff(wake_req_ff), .n_sys_ff(n_sys_ff), .n_hs_ff(n_hs_ff),
        .n_ls_ff(n_ls_ff));
    // ----------------------------------------------------------------
    // Bus tasks and compare
    // ----------------------------------------------------------------
    // One AHB single transfer; read data taken at the data-phase edge
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata_ff;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Cycles between two sys ticks
    task gap;
        g = 0;
        @(posedge hclk iff sys_clk_en_ff);
        do begin @(posedge hclk); g++; end while (!sys_clk_en_ff);
    endtask
    task results;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reg;
        xfer(0, 0, 0);
        chk(rd, 32'he0);
        chk({op_mode_ff, ls_osc_on_ff, hs_osc_on_ff, hresp_ff}, {`SCM_MODE_SLOW, 3'h4});
        xfer(1, 0, 32'hff);
        xfer(0, 0, 0);
        chk(rd, 32'he7);
        xfer(0, 32'h4, 0);
        chk(rd, 0);
        i = 0;
        do begin xfer(0, 0, 0); i++; end while (rd[3] !== 1'b1 && i < 1000);
        chk({rd, hs_osc_on_ff}, {32'hef, 1'b1});
    endtask
    task t_sel;
        for (int s = 0; s < 8; s++)
        begin
            xfer(1, 0, {24'h0, s[2:0], 5'h04});
            repeat (6) @(posedge hclk iff sys_clk_en_ff);
            gap;
            chk(g, s == 7 ? `SCM_LS_DIV : `SCM_HS_DIV << s);
            chk({cpu_clk_en_ff, sys_clk_en_ff}, 2'h3);
            chk({op_mode_ff, ls_osc_on_ff}, {s == 7 ? `SCM_MODE_SLOW : `SCM_MODE_FAST, 1'b1});
        end
        chk(hs_osc_on_ff, 1);
        xfer(1, 0, 32'he0);
        repeat (3) @(posedge hclk);
        chk(hs_osc_on_ff, 0);
    endtask
    task t_halt;
        for (int k = 0; k < 5; k++)
        begin
            wdt_en <= (k == 4);
            xfer(1, 0, {24'h0, 6'h39, k[1:0]});
            go_halt <= 1;
            @(posedge hclk);
            go_halt <= 0;
            repeat (3) @(posedge hclk);
            chk(op_mode_ff, md[k]);
            // Let the last tick launched before the gates closed be counted
            @(posedge hclk);
            {s0, h0, l0, c0} = {n_sys_ff, n_hs_ff, n_ls_ff, n_cpu};
            repeat (3200) @(posedge hclk);
            chk({n_sys_ff > s0, n_ls_ff > l0}, {2{k == 1 || k == 3}});
            chk(n_hs_ff > h0, 5'h0c >> k & 1'b1);
            chk(n_cpu > c0, 1'b0);
            if (k[1:0] == 0)
                chk(ls_osc_on_ff, k == 4);
            go_wake <= 1;
            @(posedge hclk);
            go_wake <= 0;
            repeat (3) @(posedge hclk);
        end
    endtask
    // ----------------------------------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        hclk = 0;
        forever #5 hclk = ~hclk;
    end
    // CPU tick count for the halt checks
    always @(posedge hclk)
        n_cpu <= n_cpu + cpu_clk_en_ff;
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_fail++;
            $display("wrong value at %0t: run too long", $time);
            results;
        end
    end
    initial
    begin
        {hresetn, hsel, hwrite, wdt_en, go_halt, go_wake, haddr, hwdata, htrans} = '0;
        repeat (4) @(posedge hclk);
        hresetn <= 1;
        t_reg;
        t_sel;
        t_halt;
        results;
    end
endmodule // test_system_clock_mode_control
